// >>> hw/vbiap_defines.svh
// constants of the vbi ancillary packetizer: offsets, field positions, resets
// assumes inclusion by bare name from design files after the package
`ifndef VBIAP_DEFINES_SVH
`define VBIAP_DEFINES_SVH

// ==========================================================================
// register offsets
`define VBIAP_OFF_FMT       8'h4C
`define VBIAP_OFF_EVEN_LO   8'h4D
`define VBIAP_OFF_EVEN_HI   8'h4E
`define VBIAP_OFF_ODD_LO    8'h4F
`define VBIAP_OFF_ODD_HI    8'h50
`define VBIAP_OFF_STATUS    8'h51

// ==========================================================================
// field positions and reset values
`define VBIAP_FMT_BIT       0
`define VBIAP_STAT_BUSY_BIT 0
`define VBIAP_FMT_RST       1'b0
`define VBIAP_MASK_RST      16'h0000

// ==========================================================================
// packet words and layout
`define VBIAP_PRE0_WORD     10'h000
`define VBIAP_PRE1_WORD     10'h3FF
`define VBIAP_DID_WORD      10'h140
`define VBIAP_PAD_BYTE      8'h00
`define VBIAP_IDX_DID       4'h3
`define VBIAP_IDX_SDID      4'h4
`define VBIAP_IDX_DC        4'h5
`define VBIAP_IDX_UDW0      4'h6
`define VBIAP_DC_FOUR       2'b01
`define VBIAP_DC_EIGHT      2'b10
`define VBIAP_UDW_FOUR      4'h4
`define VBIAP_UDW_EIGHT     4'h8

`endif

// >>> hw/vbiap_pkg.sv
// types of the vbi ancillary packetizer
// assumes nothing beyond a systemverilog compiler
package vbiap_pkg;

  // ========================================================================
  // packet emitter states
  typedef enum logic [1:0] {
    VBIAP_IDLE = 2'b01,
    VBIAP_SEND = 2'b10
  } vbiap_state_t;

  // ========================================================================
  // register-side state
  typedef struct packed {
    logic        fmt_byte;
    logic [15:0] even_en;
    logic [15:0] odd_en;
    logic        dirty;
    logic        req;
    logic        sh_fmt;
    logic [15:0] sh_even;
    logic [15:0] sh_odd;
    logic [7:0]  rdata;
  } vbiap_sys_t;

  // ========================================================================
  // pixel-side state
  typedef struct packed {
    logic         ack;
    logic         fmt_byte;
    logic [15:0]  even_en;
    logic [15:0]  odd_en;
    logic         pend;
    logic         pend_even;
    logic         pend_dbl;
    logic [3:0]   pend_line;
    logic [31:0]  pend_bytes;
    vbiap_state_t state;
    logic [3:0]   idx;
    logic         tx_even;
    logic         tx_dbl;
    logic         tx_byte;
    logic [3:0]   tx_line;
    logic [31:0]  tx_bytes;
    logic [6:0]   csum;
    logic [9:0]   vid_out;
    logic         anc_flag;
  } vbiap_pix_t;

endpackage : vbiap_pkg

// >>> hw/vbiap_sync.sv
// three-stage synchroniser with agreement filter
// assumes din is quasi-static or a toggle from another clock domain
`timescale 1ns/10ps

module vbiap_sync #(
  parameter int         W   = 1,
  parameter logic [0:0] RST = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } vbiap_sync_st_t;

  vbiap_sync_st_t st_q;
  vbiap_sync_st_t st_d;

  // first stage feeds only the second; output moves once stages two and three agree
  always_comb begin
    st_d    = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.out = st_q.s3;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= {4{{W{RST}}}};
    end else begin
      st_q <= st_d;
    end
  end

  assign dout_q = st_q.out;

endmodule : vbiap_sync

// >>> hw/vbiap_packetizer.sv
// vbi ancillary packetizer: registers on sys_clk, packet insertion on pix_clk
// assumes slicer results and video timing arrive on pix_clk, registers on sys_clk
`timescale 1ns/10ps
`include "vbiap_defines.svh"

// Contract
// - sixteen-bit line enable mask for even fields
// - separate sixteen-bit line enable mask, odd fields
// - recovered data never readable through register port
// - packet only if enabled and data detected
// - packet starts word right after eav
// - preamble is zeros word then two ones
// - identification word fixed, two low bits zero
// - secondary id bit seven marks even field
// - secondary id bit six marks double rate
// - secondary id bits five..two carry line code
// - even parity in bit eight, bit nine inverse
// - data count bits three..two give words/4
// - word allocation per rate and mode, padded
// - byte mode whole bytes, nibble mode halves
// - checksum sums bits eight..two, low bits zero
// - checksum bit nine inverts checksum bit eight
// - guide data only on ntsc, captions always
// - format select bit zero at 0x4c
module vbiap_packetizer (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        pix_clk,
  input  wire logic [9:0]  vid_in,
  input  wire logic        vid_eav_end,
  input  wire logic        vid_line_sel,
  input  wire logic [3:0]  vid_line_idx,
  input  wire logic        vid_field_even,
  input  wire logic        std_ntsc,
  input  wire logic        slc_valid,
  input  wire logic        slc_guide,
  input  wire logic        slc_double,
  input  wire logic [31:0] slc_bytes,
  output logic      [9:0]  vid_out,
  output logic             anc_flag
);

  // ========================================================================
  // helper functions

  // parity-protected word: bit 8 makes bits 8..0 even, bit 9 its inverse
  function automatic logic [9:0] vbiap_par_word(input logic [7:0] low);
    logic p;
    p = ^low;
    vbiap_par_word = {~p, p, low};
  endfunction : vbiap_par_word

  // user word at position k of the user section
  function automatic logic [9:0] vbiap_udw(input logic [3:0]  k,
                                           input logic        byte_mode,
                                           input logic [31:0] bytes,
                                           input logic        dbl);
    logic [7:0] b;
    logic [1:0] sel;
    vbiap_udw = 10'h000;
    b   = 8'h00;
    // byte mode spends one word per byte, nibble mode two
    sel = byte_mode ? k[1:0] : k[2:1];
    case (sel)
      2'd0:    b = bytes[31:24];
      2'd1:    b = bytes[23:16];
      2'd2:    b = bytes[15:8];
      default: b = bytes[7:0];
    endcase
    if (byte_mode) begin
      // single rate in byte mode carries two padding words after the data
      if (!dbl && k[1]) begin
        vbiap_udw = vbiap_par_word(`VBIAP_PAD_BYTE);
      end else begin
        vbiap_udw = {b, 2'b00};
      end
    end else begin
      // upper nibble at even positions, lower nibble at odd positions
      vbiap_udw = vbiap_par_word({2'b00, (k[0] ? b[3:0] : b[7:4]), 2'b00});
    end
  endfunction : vbiap_udw

  // data count code; only double rate in nibble mode needs eight user words
  function automatic logic [1:0] vbiap_dc(input logic dbl, input logic byte_mode);
    vbiap_dc = (dbl && !byte_mode) ? `VBIAP_DC_EIGHT : `VBIAP_DC_FOUR;
  endfunction : vbiap_dc

  // user word count for a packet, kept in step with the data count code
  function automatic logic [3:0] vbiap_nudw(input logic dbl, input logic byte_mode);
    vbiap_nudw = (vbiap_dc(dbl, byte_mode) == `VBIAP_DC_EIGHT) ? `VBIAP_UDW_EIGHT : `VBIAP_UDW_FOUR;
  endfunction : vbiap_nudw

  // ========================================================================
  // register side (sys_clk)

  // register-side state, its next value and the handshake view
  vbiap_pkg::vbiap_sys_t s_q;
  vbiap_pkg::vbiap_sys_t s_d;
  logic                  ack_sys;
  logic                  busy;
  logic                  p_ack_w;

  // acknowledge toggle returns from the pixel domain
  vbiap_sync #(
    .W   (1),
    .RST (1'b0)
  ) u_ack_sync (
    .clk    (sys_clk),
    .reset  (reset),
    .din    (p_ack_w),
    .dout_q (ack_sys)
  );

  // snapshot in flight until the acknowledge toggle comes back
  assign busy = (s_q.req != ack_sys);

  // register writes, reads and launch of a configuration snapshot
  always_comb begin
    s_d = s_q;
    // with clk_en low no strobe is taken and nothing moves
    if (clk_en) begin
      if (!busy && s_q.dirty) begin
        // snapshot stays frozen until the pixel side acknowledges
        s_d.sh_fmt  = s_q.fmt_byte;
        s_d.sh_even = s_q.even_en;
        s_d.sh_odd  = s_q.odd_en;
        s_d.req     = ~s_q.req;
        s_d.dirty   = 1'b0;
      end
      if (reg_wr) begin
        // unmapped offsets store nothing but still relaunch the snapshot
        case (reg_addr)
          `VBIAP_OFF_FMT:     s_d.fmt_byte      = reg_wdata[`VBIAP_FMT_BIT];
          `VBIAP_OFF_EVEN_LO: s_d.even_en[7:0]  = reg_wdata;
          `VBIAP_OFF_EVEN_HI: s_d.even_en[15:8] = reg_wdata;
          `VBIAP_OFF_ODD_LO:  s_d.odd_en[7:0]   = reg_wdata;
          `VBIAP_OFF_ODD_HI:  s_d.odd_en[15:8]  = reg_wdata;
          default:            ;
        endcase
        // a write in the launch cycle sets dirty again, so it is never lost
        s_d.dirty = 1'b1;
      end
      if (reg_rd) begin
        // no sliced data is mapped here; it only leaves through the video stream
        case (reg_addr)
          `VBIAP_OFF_FMT:     s_d.rdata = {7'h00, s_q.fmt_byte};
          `VBIAP_OFF_EVEN_LO: s_d.rdata = s_q.even_en[7:0];
          `VBIAP_OFF_EVEN_HI: s_d.rdata = s_q.even_en[15:8];
          `VBIAP_OFF_ODD_LO:  s_d.rdata = s_q.odd_en[7:0];
          `VBIAP_OFF_ODD_HI:  s_d.rdata = s_q.odd_en[15:8];
          `VBIAP_OFF_STATUS:  s_d.rdata = {7'h00, (busy | s_q.dirty)};
          default:            s_d.rdata = 8'h00;
        endcase
      end
    end
  end

  // register-side flops; reset loads constants only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q.fmt_byte <= `VBIAP_FMT_RST;
      s_q.even_en  <= `VBIAP_MASK_RST;
      s_q.odd_en   <= `VBIAP_MASK_RST;
      s_q.dirty    <= 1'b0;
      s_q.req      <= 1'b0;
      s_q.sh_fmt   <= `VBIAP_FMT_RST;
      s_q.sh_even  <= `VBIAP_MASK_RST;
      s_q.sh_odd   <= `VBIAP_MASK_RST;
      s_q.rdata    <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // read data leaves straight from its flop
  assign reg_rdata = s_q.rdata;

  // ========================================================================
  // pixel side (pix_clk)

  // pixel-side state, its next value and the synchronised controls
  vbiap_pkg::vbiap_pix_t p_q;
  vbiap_pkg::vbiap_pix_t p_d;
  logic                  req_pix;
  logic                  ce_pix;
  logic                  line_on;
  logic                  accept;
  logic [3:0]            cs_idx;
  logic [9:0]            word;

  // acknowledge toggle handed back to the register side
  assign p_ack_w = p_q.ack;

  // request toggle from the register side
  vbiap_sync #(
    .W   (1),
    .RST (1'b0)
  ) u_req_sync (
    .clk    (pix_clk),
    .reset  (reset),
    .din    (s_q.req),
    .dout_q (req_pix)
  );

  // clock enable is a level from the other domain
  vbiap_sync #(
    .W   (1),
    .RST (1'b0)
  ) u_ce_sync (
    .clk    (pix_clk),
    .reset  (reset),
    .din    (clk_en),
    .dout_q (ce_pix)
  );

  // enable check for the line now being sliced
  assign line_on = vid_line_sel &&
                   (vid_field_even ? p_q.even_en[vid_line_idx]
                                   : p_q.odd_en[vid_line_idx]);
  // guide data is dropped unless the input standard is ntsc
  assign accept  = slc_valid && line_on && (!slc_guide || std_ntsc);

  // index of the checksum word
  assign cs_idx = 4'(`VBIAP_IDX_UDW0 + vbiap_nudw(p_q.tx_dbl, p_q.tx_byte));

  // word selection by position in the packet
  always_comb begin
    word = `VBIAP_PRE0_WORD;
    if (p_q.idx == 4'h0) begin
      word = `VBIAP_PRE0_WORD;
    end else if (p_q.idx < `VBIAP_IDX_DID) begin
      word = `VBIAP_PRE1_WORD;
    end else if (p_q.idx == `VBIAP_IDX_DID) begin
      word = `VBIAP_DID_WORD;
    end else if (p_q.idx == `VBIAP_IDX_SDID) begin
      word = vbiap_par_word({p_q.tx_even,
                             p_q.tx_dbl,
                             p_q.tx_line, 2'b00});
    end else if (p_q.idx == `VBIAP_IDX_DC) begin
      word = vbiap_par_word({4'h0, vbiap_dc(p_q.tx_dbl, p_q.tx_byte), 2'b00});
    end else if (p_q.idx < cs_idx) begin
      word = vbiap_udw(4'(p_q.idx - `VBIAP_IDX_UDW0), p_q.tx_byte, p_q.tx_bytes, p_q.tx_dbl);
    end else begin
      // low bits stay zero; bit nine keeps the word off the reserved codes
      word = {~p_q.csum[6], p_q.csum, 2'b00};
    end
  end

  // configuration capture, slicer capture and packet emission
  always_comb begin
    p_d = p_q;
    // a frozen enable also holds the outgoing word; pass-through stalls with it
    if (ce_pix) begin
      if (req_pix != p_q.ack) begin
        // snapshot is stable on the register side while req and ack differ
        p_d.fmt_byte = s_q.sh_fmt;
        p_d.even_en  = s_q.sh_even;
        p_d.odd_en   = s_q.sh_odd;
        p_d.ack      = req_pix;
      end
      p_d.vid_out  = vid_in;
      p_d.anc_flag = 1'b0;
      case (p_q.state)
        vbiap_pkg::VBIAP_IDLE: begin
          if (vid_eav_end && p_q.pend) begin
            // first blanking word after eav becomes the preamble
            p_d.state    = vbiap_pkg::VBIAP_SEND;
            p_d.idx      = 4'h0;
            p_d.csum     = 7'h00;
            p_d.tx_even  = p_q.pend_even;
            p_d.tx_dbl   = p_q.pend_dbl;
            p_d.tx_byte  = p_q.fmt_byte;
            p_d.tx_line  = p_q.pend_line;
            p_d.tx_bytes = p_q.pend_bytes;
            p_d.pend     = 1'b0;
          end
        end
        vbiap_pkg::VBIAP_SEND: begin
          p_d.vid_out  = word;
          p_d.anc_flag = 1'b1;
          p_d.idx      = p_q.idx + 4'h1;
          // checksum runs from the identification word to the last user word
          if (p_q.idx >= `VBIAP_IDX_DID && p_q.idx < cs_idx) begin
            p_d.csum = p_q.csum + word[8:2];
          end
          if (p_q.idx == cs_idx) begin
            p_d.state = vbiap_pkg::VBIAP_IDLE;
          end
        end
        default: begin
          p_d.state = vbiap_pkg::VBIAP_IDLE;
        end
      endcase
      // a capture in the start cycle wins over the clear of pend
      if (accept) begin
        p_d.pend       = 1'b1;
        p_d.pend_even  = vid_field_even;
        p_d.pend_dbl   = slc_guide && slc_double;
        p_d.pend_line  = vid_line_idx;
        p_d.pend_bytes = slc_bytes;
      end
    end
  end

  // pixel-side flops; reset loads constants only
  always_ff @(posedge pix_clk or posedge reset) begin
    if (reset) begin
      p_q.ack        <= 1'b0;
      p_q.fmt_byte   <= `VBIAP_FMT_RST;
      p_q.even_en    <= `VBIAP_MASK_RST;
      p_q.odd_en     <= `VBIAP_MASK_RST;
      p_q.pend       <= 1'b0;
      p_q.pend_even  <= 1'b0;
      p_q.pend_dbl   <= 1'b0;
      p_q.pend_line  <= 4'h0;
      p_q.pend_bytes <= 32'h0000_0000;
      p_q.state      <= vbiap_pkg::VBIAP_IDLE;
      p_q.idx        <= 4'h0;
      p_q.tx_even    <= 1'b0;
      p_q.tx_dbl     <= 1'b0;
      p_q.tx_byte    <= 1'b0;
      p_q.tx_line    <= 4'h0;
      p_q.tx_bytes   <= 32'h0000_0000;
      p_q.csum       <= 7'h00;
      p_q.vid_out    <= 10'h000;
      p_q.anc_flag   <= 1'b0;
    end else begin
      p_q <= p_d;
    end
  end

  // receivers on an eight-bit bus drop bits 1..0; every word keeps them non-vital
  assign vid_out  = p_q.vid_out;
  assign anc_flag = p_q.anc_flag;

endmodule : vbiap_packetizer

// >>> testbench/vbiap_packetizer_sva.sv
// assertions on the ports of the vbi ancillary packetizer
// assumes binding onto the packetizer top with ports connected by name
`timescale 1ns/10ps

module vbiap_packetizer_sva (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       pix_clk,
  input wire logic       vid_eav_end,
  input wire logic [9:0] vid_out,
  input wire logic       anc_flag
);
  logic [4:0] wcnt_q;

  // ========================================================================
  // word counter inside a packet; holds the word count in the cycle the flag drops, then zero until the next packet
  always_ff @(posedge pix_clk or posedge reset) begin
    if (reset) begin
      wcnt_q <= 5'h00;
    end else begin
      wcnt_q <= anc_flag ? wcnt_q + 5'h01 : 5'h00;
    end
  end

  // ========================================================================
  // packet framing
  AST_PRE_ZERO: assert property (@(posedge pix_clk) disable iff (reset)
    $rose(anc_flag) |-> vid_out == 10'h000) else $error("packet opens without zero word");
  AST_PRE_ONES: assert property (@(posedge pix_clk) disable iff (reset)
    $rose(anc_flag) |=> (anc_flag && vid_out == 10'h3FF) [*2] ##1 vid_out == 10'h140)
    else $error("preamble or identification word wrong");
  AST_AFTER_EAV: assert property (@(posedge pix_clk) disable iff (reset)
    $rose(anc_flag) |-> $past(vid_eav_end, 2)) else $error("packet not right after eav");
  AST_SDID_PAR: assert property (@(posedge pix_clk) disable iff (reset)
    anc_flag && wcnt_q == 5'h04 |-> (^vid_out[8:0]) == 1'b0 && vid_out[9] != vid_out[8])
    else $error("secondary id parity wrong");
  AST_SDID_LOW: assert property (@(posedge pix_clk) disable iff (reset)
    anc_flag && wcnt_q == 5'h04 |-> vid_out[1:0] == 2'b00) else $error("secondary id low bits set");
  AST_DC_WORD: assert property (@(posedge pix_clk) disable iff (reset)
    anc_flag && wcnt_q == 5'h05 |-> vid_out[7:4] == 4'h0 && vid_out[1:0] == 2'b00
    && (vid_out[3:2] == 2'b01 || vid_out[3:2] == 2'b10)) else $error("count word malformed");
  AST_CS_INV: assert property (@(posedge pix_clk) disable iff (reset)
    $fell(anc_flag) |-> $past(vid_out[9]) != $past(vid_out[8]) && $past(vid_out[1:0]) == 2'b00)
    else $error("checksum word malformed");
  AST_LEN: assert property (@(posedge pix_clk) disable iff (reset)
    $fell(anc_flag) |-> wcnt_q == 5'h0B || wcnt_q == 5'h0F) else $error("packet length wrong");

  // ========================================================================
  // register port
  AST_NO_DATA_RD: assert property (@(posedge sys_clk) disable iff (reset)
    reg_rd && clk_en && reg_addr == 8'h99 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_FMT_RD: assert property (@(posedge sys_clk) disable iff (reset)
    reg_rd && clk_en && reg_addr == 8'h4C |=> reg_rdata[7:1] == 7'h00) else $error("format reg upper bits");
endmodule : vbiap_packetizer_sva

// >>> testbench/vbiap_rx_model.sv
// receiver model: gathers the words of each ancillary packet from the stream
// assumes anc_flag frames the packet words on pix_clk
`timescale 1ns/10ps

module vbiap_rx_model (
  input  wire logic             pix_clk,
  input  wire logic             reset,
  input  wire logic [9:0]       vid_out,
  input  wire logic             anc_flag,
  output logic      [15:0][9:0] words,
  output int                    n,
  output int                    pkts,
  output logic                  pre_ok
);
  int cnt;

  // ========================================================================
  // capture; a packet is closed when the flag drops
  always_ff @(posedge pix_clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      n <= 0;
      pkts <= 0;
      words <= '0;
    end else if (anc_flag) begin
      words[cnt[3:0]] <= vid_out;
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      n <= cnt;
      pkts <= pkts + 1;
      cnt <= 0;
    end
  end

  // an eight-bit receiver judges the preamble on the upper bits only
  assign pre_ok = words[0][9:2] == 8'h00 && words[1][9:2] == 8'hFF && words[2][9:2] == 8'hFF;
endmodule : vbiap_rx_model

// >>> testbench/tb_vbiap_packetizer.sv
// testbench of the vbi ancillary packetizer: registers, packets, refusals
// assumes design files, checker and receiver model compiled before it
`timescale 1ns/10ps

module tb_vbiap_packetizer;
  logic             sys_clk, reset, reg_wr, reg_rd, pix_clk, vid_eav_end, vid_line_sel, anc_flag, clk_en;
  logic             vid_field_even, std_ntsc, slc_valid, slc_guide, slc_double, pre_ok, cur_fmt;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata;
  logic [3:0]       vid_line_idx;
  logic [31:0]      slc_bytes;
  logic [9:0]       vid_in, vid_out;
  logic [15:0][9:0] words;
  logic [9:0]       exp_q[$];
  int               n, pkts, failures, checks_done;

  vbiap_packetizer uut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pix_clk(pix_clk),
    .vid_in(vid_in), .vid_eav_end(vid_eav_end), .vid_line_sel(vid_line_sel), .vid_line_idx(vid_line_idx),
    .vid_field_even(vid_field_even), .std_ntsc(std_ntsc), .slc_valid(slc_valid), .slc_guide(slc_guide),
    .slc_double(slc_double), .slc_bytes(slc_bytes), .vid_out(vid_out), .anc_flag(anc_flag));
  vbiap_rx_model rx (.pix_clk(pix_clk), .reset(reset), .vid_out(vid_out), .anc_flag(anc_flag),
    .words(words), .n(n), .pkts(pkts), .pre_ok(pre_ok));

  // ========================================================================
  // clocks: pixel clock free running, phase unrelated to sys_clk
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    pix_clk = 1'b0;
    #13;
    forever #80 pix_clk = ~pix_clk;
  end

  // ========================================================================
  // helpers
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
  endtask : wr

  // rdata stands until the next read, so sample one edge late
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    @(posedge sys_clk) #1;
    v = reg_rdata;
  endtask : rd

  // write, then wait until the pixel side has taken it
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    wr(a, d);
    v = 8'h01;
    for (int i = 0; i < 400 && v[0] !== 1'b0; i++) rd(8'h51, v);
    if (v[0] !== 1'b0) begin
      failures++;
      final_report();
    end
  endtask : cfg

  function automatic logic [9:0] ep(input logic [7:0] v);
    return {~(^v), ^v, v};
  endfunction : ep

  task automatic build(input logic ev, input logic dbl, input logic [3:0] ln, input logic [31:0] b);
    logic [6:0] cs;
    logic [7:0] by;
    exp_q = '{10'h000, 10'h3FF, 10'h3FF, 10'h140};
    exp_q.push_back(ep({ev, dbl, ln, 2'b00}));
    exp_q.push_back(ep({4'h0, (dbl && !cur_fmt) ? 2'b10 : 2'b01, 2'b00}));
    for (int i = 0; i < (dbl ? 4 : 2); i++) begin
      by = b[31 - 8 * i -: 8];
      if (cur_fmt) begin
        exp_q.push_back({by, 2'b00});
      end else begin
        exp_q.push_back(ep({2'b00, by[7:4], 2'b00}));
        exp_q.push_back(ep({2'b00, by[3:0], 2'b00}));
      end
    end
    if (cur_fmt && !dbl) begin
      exp_q.push_back(10'h200);
      exp_q.push_back(10'h200);
    end
    cs = 7'h00;
    for (int i = 3; i < exp_q.size(); i++) cs += exp_q[i][8:2];
    exp_q.push_back({~cs[6], cs, 2'b00});
  endtask : build

  // one vbi line with slicer result, then the eav that ends it
  task automatic pkt(input logic ev, input logic [3:0] ln, input logic gd, input logic dbl,
                     input logic ntsc, input logic vld, input logic [31:0] b, input logic ex);
    int p0;
    p0 = pkts;
    @(posedge pix_clk) #1;
    vid_line_sel = 1'b1;
    vid_line_idx = ln;
    vid_field_even = ev;
    slc_guide = gd;
    slc_double = dbl;
    std_ntsc = ntsc;
    slc_bytes = b;
    slc_valid = vld;
    @(posedge pix_clk) #1;
    slc_valid = 1'b0;
    vid_eav_end = 1'b1;
    @(posedge pix_clk) #1;
    vid_eav_end = 1'b0;
    vid_line_sel = 1'b0;
    for (int i = 0; i < 24 && pkts == p0; i++) @(posedge pix_clk) #1;
    if (ex && pkts == p0) begin
      failures++;
      final_report();
    end
    check(pkts - p0, {31'h0000_0000, ex});
    if (ex) begin
      build(ev, gd && dbl, ln, b);
      check(n, exp_q.size());
      foreach (exp_q[i]) check(words[i], exp_q[i]);
      check(pre_ok, 1'b1);
    end
  endtask : pkt

  // ========================================================================
  // scenarios
  task automatic t_regs;
    logic [7:0] v;
    logic [7:0] adr [4] = '{8'h4D, 8'h4E, 8'h4F, 8'h50};
    logic [7:0] val [4] = '{8'h21, 8'h01, 8'h01, 8'h80};
    rd(8'h4C, v);
    check(v, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(adr[i], v);
      check(v, 8'h00);
      cfg(adr[i], val[i]);
      rd(adr[i], v);
      check(v, val[i]);
    end
    rd(8'h99, v);
    check(v, 8'h00);
    // a write while clk_en is low must not be taken
    clk_en = 1'b0;
    wr(8'h4C, 8'h01);
    clk_en = 1'b1;
    rd(8'h4C, v);
    check(v, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // nibble mode: double, single, and a caption on pal
  task automatic t_nibble;
    pkt(1'b1, 4'h5, 1'b1, 1'b1, 1'b1, 1'b1, 32'hA5C3_1E77, 1'b1);
    pkt(1'b0, 4'h0, 1'b1, 1'b0, 1'b1, 1'b1, 32'h8001_FFFF, 1'b1);
    pkt(1'b1, 4'h8, 1'b0, 1'b0, 1'b0, 1'b1, 32'h7E42_0000, 1'b1);
    $display("test nibble done");
  endtask : t_nibble

  // byte mode: caption has double set, which must be ignored
  task automatic t_byte;
    logic [7:0] v;
    cfg(8'h4C, 8'h01);
    cur_fmt = 1'b1;
    rd(8'h4C, v);
    check(v, 8'h01);
    pkt(1'b0, 4'hF, 1'b1, 1'b1, 1'b1, 1'b1, 32'h0F0F_F00F, 1'b1);
    pkt(1'b1, 4'h0, 1'b0, 1'b1, 1'b1, 1'b1, 32'hC1D2_E3F4, 1'b1);
    $display("test byte done");
  endtask : t_byte

  // disabled line, enabled line without data, guide data on pal
  task automatic t_refuse;
    pkt(1'b1, 4'h6, 1'b1, 1'b1, 1'b1, 1'b1, 32'h1234_5678, 1'b0);
    pkt(1'b1, 4'h5, 1'b1, 1'b1, 1'b1, 1'b0, 32'h1234_5678, 1'b0);
    pkt(1'b0, 4'hF, 1'b1, 1'b0, 1'b0, 1'b1, 32'h1234_5678, 1'b0);
    // outside packets the stream passes with one word of latency
    vid_in = 10'h2A8;
    @(posedge pix_clk) #1;
    check(vid_out, 10'h2A8);
    check(anc_flag, 1'b0);
    $display("test refuse done");
  endtask : t_refuse

  // ========================================================================
  // main sequence
  initial begin
    {reg_wr, reg_rd, vid_eav_end, vid_line_sel, vid_field_even, slc_valid, slc_guide, slc_double} = 8'h00;
    std_ntsc = 1'b1;
    clk_en = 1'b1;
    cur_fmt = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    vid_line_idx = 4'h0;
    slc_bytes = 32'h0000_0000;
    vid_in = 10'h040;
    failures = 0;
    checks_done = 0;
    reset = 1'b1;
    repeat (8) @(posedge sys_clk);
    @(posedge pix_clk);
    @(posedge sys_clk) #1;
    reset = 1'b0;
    repeat (6) @(posedge pix_clk) #1;
    t_regs();
    t_nibble();
    t_byte();
    t_refuse();
    final_report();
  end
endmodule : tb_vbiap_packetizer

bind vbiap_packetizer vbiap_packetizer_sva chk (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_clk(pix_clk),
  .vid_eav_end(vid_eav_end), .vid_out(vid_out), .anc_flag(anc_flag));
